// >>> hdl/sync_serial_port.sv
// slave-side synchronous serial port with slave-select synchronisation
`timescale 1ns/1ns
`default_nettype none
module sync_serial_port
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // power state
    input wire logic sleep,
    output logic wake,
    // software register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    output logic irq,
    // serial link
    spi_link_if.device link
);
    import spi_ss_pkg::*;

    logic [1:0] sck_sync; // serial clock synchroniser
    logic [1:0] ss_sync; // select synchroniser
    logic [1:0] sdi_sync; // data-in synchroniser
    logic sck_prev; // last synced clock level
    logic ss_prev; // last synced select level
    logic [7:0] shift_reg; // transmit and receive shifter
    logic [7:0] data_buffer_reg; // received byte
    logic [3:0] bit_count; // bits taken in this byte
    logic out_bit; // bit on the output pin
    logic [7:0] ctrl1; // control one
    logic [7:0] ctrl3; // control three
    logic [1:0] stat_cfg; // sample phase and edge select
    logic buffer_full; // unread byte waiting
    logic [2:0] int_stat; // sticky events
    logic [2:0] int_mask; // event enables
    logic [3:0] port_mode_select;
    logic port_enable_bit;
    logic clock_idle_polarity;
    logic clock_edge_select;
    logic slave_mode; // slave modes only
    logic ss_controlled; // select pin governs port
    logic selected; // port may shift
    logic port_reset; // clears bit counter
    logic stall; // master-mode sleep freeze
    logic lead_edge; // edge away from idle level
    logic trail_edge; // edge back to idle level
    logic sample_edge; // data-in capture edge
    logic drive_edge; // data-out update edge
    logic byte_done; // eighth bit captured
    logic data_wr; // write to data buffer
    logic data_wr_ok; // accepted write
    logic write_collision;
    logic receive_overflow;
    logic [7:0] next_shift; // shifter after capture

    assign port_mode_select = ctrl1[3:0];
    assign port_enable_bit = ctrl1[CTRL1_EN];
    assign clock_idle_polarity = ctrl1[CTRL1_CKP];
    assign clock_edge_select = stat_cfg[0];
    assign slave_mode = (port_mode_select == MODE_SLAVE_SS) ||
        (port_mode_select == MODE_SLAVE_FREE);
    assign ss_controlled = port_mode_select == MODE_SLAVE_SS;

    // two-stage synchronisers for every link input; first stage read only by second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sck_sync <= 2'h0;
            ss_sync <= 2'h3;
            sdi_sync <= 2'h0;
        end
        else if (clk_en)
        begin
            sck_sync <= {sck_sync[0], link.serial_clock_pin};
            ss_sync <= {ss_sync[0], link.slave_select_n};
            sdi_sync <= {sdi_sync[0], link.serial_in_pin};
        end
    end

    // previous synced levels for edge detection
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sck_prev <= 1'b0;
            ss_prev <= 1'b1;
        end
        else if (clk_en)
        begin
            sck_prev <= sck_sync[1];
            ss_prev <= ss_sync[1];
        end
    end

    // edges seen through the idle polarity; the serial clock alone paces the
    // shifter, so sleep in slave mode does not stop reception
    assign lead_edge = (sck_sync[1] != sck_prev) && (sck_prev == clock_idle_polarity);
    assign trail_edge = (sck_sync[1] != sck_prev) && (sck_sync[1] == clock_idle_polarity);
    assign selected = port_enable_bit && slave_mode && !(ss_controlled && ss_sync[1]);
    assign port_reset = !port_enable_bit || (ss_controlled && ss_sync[1]) ||
        (ss_controlled && ss_prev && !ss_sync[1]);
    assign stall = sleep && !slave_mode;
    // edge select high: capture on leading edge, output ahead of it
    assign sample_edge = selected && (clock_edge_select ? lead_edge : trail_edge);
    assign drive_edge = selected && (clock_edge_select ? trail_edge : lead_edge);
    assign next_shift = {shift_reg[6:0], sdi_sync[1]};
    assign byte_done = sample_edge && !port_reset && (bit_count == BITS_PER_BYTE - 4'h1);
    assign data_wr = wr && (addr == OFS_DATA);
    assign data_wr_ok = data_wr && (bit_count == 4'h0) && !ctrl1[CTRL1_WRITE_COLLISION];
    assign write_collision = data_wr && !data_wr_ok;
    assign receive_overflow = byte_done && buffer_full && !ctrl3[CTRL3_BUFFER_OVERWRITE_ENABLE];

    // bit counter; a port reset wins over counting
    always_ff @(posedge clk)
    begin
        if (rst)
            bit_count <= 4'h0;
        else if (clk_en && !stall)
        begin
            if (port_reset)
                bit_count <= 4'h0;
            else if (byte_done)
                bit_count <= 4'h0;
            else if (sample_edge)
                bit_count <= bit_count + 4'h1;
        end
    end

    // shifter: software load when idle, capture on sample edges
    always_ff @(posedge clk)
    begin
        if (rst)
            shift_reg <= REG_RST;
        else if (clk_en && !stall)
        begin
            if (data_wr_ok)
                shift_reg <= wdata;
            else if (sample_edge && !port_reset)
                shift_reg <= next_shift;
        end
    end

    // output bit: leading MSB preset while idle, then updated on drive edges
    always_ff @(posedge clk)
    begin
        if (rst)
            out_bit <= 1'b0;
        else if (clk_en && !stall)
        begin
            if (bit_count == 4'h0 && !drive_edge)
                out_bit <= data_wr_ok ? wdata[7] : shift_reg[7];
            else if (drive_edge)
                out_bit <= shift_reg[7];
        end
    end

    // floats once the synchronised select rises, two clocks after the pin, even mid-byte
    assign link.serial_out_pin = out_bit;
    assign link.serial_out_oe = selected;

    // receive buffer and full flag; a new byte's set wins over the read clear
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            data_buffer_reg <= REG_RST;
            buffer_full <= 1'b0;
        end
        else if (clk_en)
        begin
            if (byte_done && !receive_overflow)
            begin
                data_buffer_reg <= next_shift;
                buffer_full <= 1'b1;
            end
            else if (rd && addr == OFS_DATA)
                buffer_full <= 1'b0;
        end
    end

    // control one: software fields plus hardware-set collision and overflow
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl1 <= REG_RST;
        else if (clk_en)
        begin
            if (wr && addr == OFS_CTRL1)
                ctrl1 <= wdata;
            if (write_collision)
                ctrl1[CTRL1_WRITE_COLLISION] <= 1'b1;
            if (receive_overflow)
                ctrl1[CTRL1_OVF] <= 1'b1;
        end
    end

    // control three and status configuration, software only
    // sample phase is stored but unused: it must stay clear in slave mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl3 <= REG_RST;
            stat_cfg <= 2'h0;
        end
        else if (clk_en)
        begin
            if (wr && addr == OFS_CTRL3)
                ctrl3 <= wdata;
            if (wr && addr == OFS_STATUS)
                stat_cfg <= {wdata[STAT_SMP], wdata[STAT_CKE]};
        end
    end

    // sticky events, write one to clear, set beats clear
    always_ff @(posedge clk)
    begin
        if (rst)
            int_stat <= 3'h0;
        else if (clk_en)
        begin
            int_stat <= (int_stat & ~((wr && addr == OFS_INT_STAT) ? wdata[2:0] : 3'h0)) |
                {receive_overflow, write_collision, byte_done};
        end
    end

    // interrupt mask
    always_ff @(posedge clk)
    begin
        if (rst)
            int_mask <= INT_MASK_RST;
        else if (clk_en && wr && addr == OFS_INT_MASK)
            int_mask <= wdata[2:0];
    end

    // byte completion wakes a sleeping device only when unmasked
    assign irq = |(int_stat & int_mask);
    assign wake = sleep && irq;

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= REG_RST;
        else if (clk_en)
        begin
            if (!rd)
                rdata <= REG_RST;
            else
            begin
                case (addr)
                    OFS_DATA: rdata <= data_buffer_reg;
                    OFS_CTRL1: rdata <= ctrl1;
                    OFS_CTRL3: rdata <= ctrl3;
                    OFS_STATUS: rdata <= {stat_cfg, 5'h0, buffer_full};
                    OFS_INT_STAT: rdata <= {5'h0, int_stat};
                    OFS_INT_MASK: rdata <= {5'h0, int_mask};
                    default: rdata <= REG_RST;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// >>> hdl/spi_ss_pkg.sv
// shared constants for the slave-select synchronised serial port and its master
package spi_ss_pkg;
    // register offsets on the software port
    localparam logic [3:0] OFS_DATA = 4'h0;
    localparam logic [3:0] OFS_CTRL1 = 4'h1;
    localparam logic [3:0] OFS_CTRL3 = 4'h2;
    localparam logic [3:0] OFS_STATUS = 4'h3;
    localparam logic [3:0] OFS_INT_STAT = 4'h4;
    localparam logic [3:0] OFS_INT_MASK = 4'h5;
    // control one fields
    localparam int CTRL1_WRITE_COLLISION = 7;
    localparam int CTRL1_OVF = 6;
    localparam int CTRL1_EN = 5;
    localparam int CTRL1_CKP = 4;
    // control three field
    localparam int CTRL3_BUFFER_OVERWRITE_ENABLE = 4;
    // status fields
    localparam int STAT_SMP = 7;
    localparam int STAT_CKE = 6;
    localparam int STAT_BF = 0;
    // interrupt status bits
    localparam int INT_BYTE = 0;
    localparam int INT_WRITE_COLLISION = 1;
    localparam int INT_OVF = 2;
    localparam logic [2:0] INT_MASK_RST = 3'h0;
    // mode field encodings
    localparam logic [3:0] MODE_SLAVE_SS = 4'h4;
    localparam logic [3:0] MODE_SLAVE_FREE = 4'h5;
    localparam logic [3:0] MODE_RST = 4'h0;
    localparam logic [7:0] REG_RST = 8'h00;
    // byte framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    // master timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 1000;
    localparam logic [7:0] HALF_CYCLES = 8'((LINK_PERIOD_NS / 2) / CLK_PERIOD_NS);
endpackage

// >>> hdl/spi_link_if.sv
// serial link between the external master and the slave port
`timescale 1ns/1ns
`default_nettype none
interface spi_link_if;
    logic serial_clock_pin; // driven by master
    logic slave_select_n; // driven by master
    logic serial_in_pin; // master to slave data
    logic serial_out_pin; // slave to master data
    logic serial_out_oe; // slave drives serial_out_pin
    // slave end
    modport device
    (
        input serial_clock_pin,
        input slave_select_n,
        input serial_in_pin,
        output serial_out_pin,
        output serial_out_oe
    );
    // master end
    modport master
    (
        output serial_clock_pin,
        output slave_select_n,
        output serial_in_pin,
        input serial_out_pin,
        input serial_out_oe
    );
endinterface
`default_nettype wire

// >>> hdl/spi_link_master.sv
// external master end: one selected byte per start request
`timescale 1ns/1ns
`default_nettype none
module spi_link_master
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic clk_en,
    // user request
    input wire logic start,
    input wire logic [7:0] tx_data,
    input wire logic cpol,
    input wire logic cke,
    // user answer
    output logic busy,
    output logic done,
    output logic [7:0] rx_data,
    // serial link
    spi_link_if.master link
);
    import spi_ss_pkg::*;

    typedef enum logic [1:0]
    {
        ST_IDLE = 2'b00,
        ST_SELECT = 2'b01,
        ST_SHIFT = 2'b10,
        ST_RELEASE = 2'b11
    } state_t;

    state_t state; // sequencer state
    logic [7:0] half_cnt; // cycles in current half period
    logic [4:0] edge_cnt; // serial clock edges issued
    logic [7:0] tx_shift; // bits still to send
    logic [7:0] rx_shift; // bits received
    logic [1:0] sdo_sync; // slave data synchroniser
    logic sck; // clock level driven
    logic ss_n; // select driven
    logic mosi; // data driven
    logic tick; // half period elapsed
    logic leading; // next edge leaves idle level

    assign tick = half_cnt == HALF_CYCLES - 8'h1;
    assign leading = !edge_cnt[0];
    assign busy = state != ST_IDLE;
    assign link.serial_clock_pin = sck;
    assign link.slave_select_n = ss_n;
    assign link.serial_in_pin = mosi;

    // slave output is a pin from outside: two flops first
    always_ff @(posedge clk)
    begin
        if (rst)
            sdo_sync <= 2'h0;
        else if (clk_en)
            sdo_sync <= {sdo_sync[0], link.serial_out_pin};
    end

    // half period divider, runs only during a transfer
    always_ff @(posedge clk)
    begin
        if (rst)
            half_cnt <= 8'h0;
        else if (clk_en)
            half_cnt <= (state == ST_IDLE || tick) ? 8'h0 : half_cnt + 8'h1;
    end

    // sequencer; select stays high between bytes
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            ss_n <= 1'b1;
            sck <= 1'b0;
            edge_cnt <= 5'h0;
            done <= 1'b0;
        end
        else if (clk_en)
        begin
            done <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    sck <= cpol;
                    if (start)
                    begin
                        ss_n <= 1'b0;
                        edge_cnt <= 5'h0;
                        state <= ST_SELECT;
                    end
                end
                ST_SELECT:
                    if (tick)
                        state <= ST_SHIFT;
                ST_SHIFT:
                    if (tick)
                    begin
                        sck <= ~sck;
                        edge_cnt <= edge_cnt + 5'h1;
                        if (edge_cnt == EDGES_PER_BYTE - 5'h1)
                            state <= ST_RELEASE;
                    end
                ST_RELEASE:
                    if (tick)
                    begin
                        ss_n <= 1'b1;
                        done <= 1'b1;
                        state <= ST_IDLE;
                    end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // data shifters, MSB first; edge select high puts MSB out before first edge
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_shift <= REG_RST;
            rx_shift <= REG_RST;
            mosi <= 1'b0;
            rx_data <= REG_RST;
        end
        else if (clk_en)
        begin
            if (state == ST_IDLE && start)
            begin
                tx_shift <= cke ? {tx_data[6:0], 1'b0} : tx_data;
                mosi <= cke ? tx_data[7] : 1'b0;
            end
            else if (state == ST_SHIFT && tick)
            begin
                if (leading == cke)
                    rx_shift <= {rx_shift[6:0], sdo_sync[1]};
                else
                begin
                    mosi <= tx_shift[7];
                    tx_shift <= {tx_shift[6:0], 1'b0};
                end
            end
            else if (state == ST_RELEASE && tick)
                rx_data <= rx_shift;
        end
    end
endmodule
`default_nettype wire

// >>> sim/spi_ss_chk.sv
// concurrent checks on the serial link between master end and slave port
`timescale 1ns/1ns
`default_nettype none
module spi_ss_chk
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link signals, watched only
    input wire logic serial_clock_pin,
    input wire logic slave_select_n,
    input wire logic serial_in_pin,
    input wire logic serial_out_pin,
    input wire logic serial_out_oe
);
    import spi_ss_pkg::*;
    // frame length window, loose around the fixed select, shift and release phases
    localparam int LOW_MIN = 16 * HALF_CYCLES;
    localparam int LOW_MAX = 19 * HALF_CYCLES;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic [4:0] edge_cnt; // link clock toggles in this frame
    logic [7:0] low_cnt; // cycles with select low
    // restart both counts at each select fall
    always_ff @(posedge clk)
    begin
        if (rst || $fell(slave_select_n))
        begin
            edge_cnt <= 5'h00;
            low_cnt <= 8'h00;
        end
        else if (!slave_select_n)
        begin
            edge_cnt <= edge_cnt + 5'($changed(serial_clock_pin));
            low_cnt <= low_cnt + 8'h01;
        end
    end
    a_sel_drives_out: assert property (!slave_select_n [*4] |-> serial_out_oe)
        else $error("output not driven while selected");
    a_desel_floats: assert property ($rose(slave_select_n) |-> ##[1:4] !serial_out_oe)
        else $error("output still driven after deselect");
    a_idle_quiet: assert property (slave_select_n [*4] |-> !serial_out_oe)
        else $error("output driven while deselected");
    a_sync_latency: assert property ($rose(serial_out_oe) |-> !$past(slave_select_n))
        else $error("output enabled before select passed synchroniser");
    a_sck_spacing: assert property ($changed(serial_clock_pin) |=> $stable(serial_clock_pin) [*8])
        else $error("link clock half period too short");
    a_first_edge_wait: assert property ($fell(slave_select_n) |-> $stable(serial_clock_pin) [*8])
        else $error("link clock moved right after select fall");
    a_edges_per_byte: assert property ($rose(slave_select_n) |-> edge_cnt == EDGES_PER_BYTE)
        else $error("frame did not carry sixteen clock edges");
    a_frame_length: assert property ($rose(slave_select_n) |-> low_cnt >= LOW_MIN && low_cnt <= LOW_MAX)
        else $error("select low for a wrong number of cycles");
    c_frame: cover property ($rose(slave_select_n));
    c_drive: cover property ($rose(serial_out_oe));
    c_float: cover property ($fell(serial_out_oe));
endmodule
`default_nettype wire

// >>> sim/spi_slave_select_sync_tb_top.sv
// testbench: master end against slave port, plus a bench-driven faulty link
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, gt) \
    begin n_compared++; if ((gt) !== (ex)) \
    begin errors++; $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); end end
module spi_slave_select_sync_tb_top;
    import spi_ss_pkg::*;
    // clock, reset, power
    logic clk = 1'b0, rst = 1'b1, clk_en = 1'b1, sleep = 1'b0;
    // register ports of the two slave ports
    logic [3:0] addr [2] = '{4'h0, 4'h0};
    logic [7:0] wdata [2] = '{8'h00, 8'h00};
    logic wr [2] = '{1'b0, 1'b0};
    logic rd [2] = '{1'b0, 1'b0};
    logic [7:0] rdata [2];
    logic irq [2];
    logic wake [2];
    // master user side
    logic start = 1'b0, cpol = 1'b0, cke = 1'b0, busy, done;
    logic [7:0] tx = 8'h00, mrx, mt, st, so, cfg;
    int errors = 0, n_compared = 0, cycles = 0;
    spi_link_if link ();
    spi_link_if link_f ();
    spi_link_master spi_link_master_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .start(start),
        .tx_data(tx), .cpol(cpol), .cke(cke), .busy(busy), .done(done), .rx_data(mrx), .link(link));
    sync_serial_port sync_serial_port_inst (.clk(clk), .rst(rst), .clk_en(clk_en), .sleep(sleep),
        .wake(wake[0]), .addr(addr[0]), .wdata(wdata[0]), .wr(wr[0]), .rd(rd[0]),
        .rdata(rdata[0]), .irq(irq[0]), .link(link));
    // second port faces the bench, which breaks framing on purpose
    sync_serial_port sync_serial_port_f_inst (.clk(clk), .rst(rst), .clk_en(clk_en),
        .sleep(1'b0), .wake(wake[1]), .addr(addr[1]), .wdata(wdata[1]), .wr(wr[1]),
        .rd(rd[1]), .rdata(rdata[1]), .irq(irq[1]), .link(link_f));
    spi_ss_chk spi_ss_chk_inst (.clk(clk), .rst(rst),
        .serial_clock_pin(link.serial_clock_pin), .slave_select_n(link.slave_select_n),
        .serial_in_pin(link.serial_in_pin), .serial_out_pin(link.serial_out_pin),
        .serial_out_oe(link.serial_out_oe));
    // system clock, 50 ns
    initial
        forever #25 clk = ~clk;
    // hang guard, far above the expected few thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            end_of_test();
        end
    end
    // verdict and stop
    task automatic end_of_test;
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // expected status read: sample phase clear, edge select, buffer full
    function automatic logic [7:0] stat_exp(input logic e, input logic f);
        return {1'b0, e, 5'h00, f};
    endfunction
    // one-cycle write; leading wait keeps a gap between strobes
    task automatic wreg(input int d, input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        addr[d] <= a;
        wdata[d] <= v;
        wr[d] <= 1'b1;
        @(posedge clk);
        wr[d] <= 1'b0;
        #1;
    endtask
    // read, data taken in the single cycle after the strobe
    task automatic creg(input int d, input logic [3:0] a, input logic [7:0] ex, input string nm);
        @(posedge clk);
        addr[d] <= a;
        rd[d] <= 1'b1;
        @(posedge clk);
        rd[d] <= 1'b0;
        #1;
        `CHK(nm, ex, rdata[d])
    endtask
    // one master byte; coll writes the slave buffer mid-frame
    task automatic xfer(input logic [7:0] m, input logic [7:0] s, input bit coll);
        wreg(0, OFS_DATA, s);
        @(posedge clk);
        tx <= m;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1 `CHK("busy", 1'b1, busy)
        if (coll)
        begin
            repeat (60) @(posedge clk);
            wreg(0, OFS_DATA, ~s);
        end
        // done stands one cycle: look at it mid-cycle, away from the edges
        for (int i = 0; i < 400 && done !== 1'b1; i++)
            @(negedge clk);
        `CHK("master done", 1'b1, done)
        repeat (6) @(posedge clk);
        `CHK("master rx", s, mrx)
    endtask
    // select edge off the clock phase; idle data line keeps changing
    task automatic sel(input logic v);
        #13 link_f.slave_select_n = v;
        link_f.serial_in_pin = ~link_f.serial_in_pin;
        #200;
    endtask
    // n bits msb first, 400 ns link period, slave output taken before trailing edge;
    // data moves mid low phase so it is settled at either sampling edge
    task automatic bb(input int n, input logic [7:0] v, output logic [7:0] o);
        for (int i = 7; i > 7 - n; i--)
        begin
            #100 link_f.serial_in_pin = v[i];
            #100 link_f.serial_clock_pin = 1'b1;
            #190 o[i] = link_f.serial_out_pin;
            #10 link_f.serial_clock_pin = 1'b0;
        end
    endtask
    // main sequence
    initial
    begin
        link_f.slave_select_n = 1'b1;
        link_f.serial_clock_pin = 1'b0;
        link_f.serial_in_pin = 1'b0;
        void'($urandom(32'h0067));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        wreg(0, 4'hF, 8'hFF);
        for (int a = 0; a < 16; a++)
            creg(0, 4'(a), REG_RST, "reset value");
        // every idle level and edge choice, corner bytes first
        for (int m = 0; m < 4; m++)
        begin
            cfg = {3'h1, m[1], MODE_SLAVE_SS};
            wreg(0, OFS_CTRL1, cfg);
            wreg(0, OFS_STATUS, {1'b0, m[0], 6'h00});
            cpol <= m[1];
            cke <= m[0];
            mt = (m == 0) ? 8'h80 : 8'($urandom);
            st = (m == 0) ? 8'h01 : 8'($urandom);
            xfer(mt, st, 1'b0);
            creg(0, OFS_STATUS, stat_exp(m[0], 1'b1), "full");
            creg(0, OFS_INT_STAT, 8'h01, "byte flag");
            creg(0, OFS_DATA, mt, "slave rx");
            creg(0, OFS_STATUS, stat_exp(m[0], 1'b0), "read empties");
            `CHK("irq masked", 1'b0, irq[0])
            wreg(0, OFS_INT_STAT, 8'h07);
        end
        // buffer write during a frame is refused
        xfer(8'h5A, 8'hC3, 1'b1);
        creg(0, OFS_CTRL1, cfg | 8'h80, "collision");
        creg(0, OFS_INT_STAT, 8'h03, "collision flag");
        creg(0, OFS_DATA, 8'h5A, "rx beside collision");
        wreg(0, OFS_CTRL1, cfg);
        wreg(0, OFS_INT_STAT, 8'h07);
        creg(0, OFS_CTRL1, cfg, "collision cleared");
        // reception while asleep, wake only when unmasked
        wreg(0, OFS_INT_MASK, 8'h01);
        sleep <= 1'b1;
        mt = 8'($urandom);
        xfer(mt, 8'h96, 1'b0);
        `CHK("irq", 1'b1, irq[0])
        `CHK("wake", 1'b1, wake[0])
        creg(0, OFS_DATA, mt, "asleep rx");
        wreg(0, OFS_INT_MASK, 8'h00);
        `CHK("wake masked", 1'b0, wake[0])
        sleep <= 1'b0;
        // unselected bytes count only in the free slave mode; edge select stays clear there
        for (int k = 0; k < 2; k++)
        begin
            wreg(1, OFS_CTRL1, k ? {4'h2, MODE_SLAVE_FREE} : {4'h2, MODE_SLAVE_SS});
            bb(8, 8'hA5, so);
            repeat (6) @(posedge clk);
            creg(1, OFS_INT_STAT, 8'(k), "unselected byte");
        end
        // a second unread byte is refused: buffer kept, overflow flagged
        bb(8, 8'h3C, so);
        repeat (6) @(posedge clk);
        creg(1, OFS_INT_STAT, 8'h05, "overflow flag");
        creg(1, OFS_CTRL1, {4'h6, MODE_SLAVE_FREE}, "overflow");
        `CHK("irq f masked", 1'b0, irq[1])
        creg(1, OFS_DATA, 8'hA5, "free rx");
        wreg(1, OFS_CTRL1, {4'h2, MODE_SLAVE_SS});
        wreg(1, OFS_STATUS, 8'h40);
        // select raised after three bits, then a whole byte
        wreg(1, OFS_DATA, 8'h3C);
        sel(1'b0);
        `CHK("oe on", 1'b1, link_f.serial_out_oe)
        bb(3, 8'hFF, so);
        sel(1'b1);
        `CHK("oe off", 1'b0, link_f.serial_out_oe)
        mt = 8'($urandom);
        wreg(1, OFS_DATA, 8'hC5);
        sel(1'b0);
        bb(8, mt, so);
        sel(1'b1);
        `CHK("fresh tx", 8'hC5, so)
        creg(1, OFS_DATA, mt, "fresh rx");
        // port disabled after five bits, select kept low
        sel(1'b0);
        bb(5, 8'h00, so);
        wreg(1, OFS_CTRL1, {4'h0, MODE_SLAVE_SS});
        wreg(1, OFS_CTRL1, {4'h2, MODE_SLAVE_SS});
        mt = 8'($urandom);
        bb(8, mt, so);
        sel(1'b1);
        creg(1, OFS_DATA, mt, "rx after disable");
        end_of_test();
    end
endmodule
`default_nettype wire
